// file: verilog/cscd_pkg.sv
// package for the codec serial control decoder: constants and enumerations
// assumes a single core clock; the bit clock and strobe arrive as synchronous inputs
`default_nettype none
package cscd_pkg;
    // control-address pin levels, decoded outside into two bits
    typedef enum logic [1:0] {CA_NEG, CA_DGND, CA_POS, CA_BAD} cscd_ca_type;
    // function field of the gain/loopback register
    localparam logic [1:0] FN_NORMAL = 2'h0;
    localparam logic [1:0] FN_DIG_LOOP = 2'h1;
    localparam logic [1:0] FN_ANA_LOOP = 2'h2;
    localparam logic [1:0] FN_PWRDN = 2'h3;
    // field positions
    localparam int TXG_LSB = 0;
    localparam int RXG_LSB = 3;
    localparam int FN_LSB = 6;
    localparam int TST_LSB = 6;
    localparam int SPARE_W = 6;
    // reset values
    localparam logic [7:0] GLC_RST = 8'hc0;
    localparam logic [7:0] OTC_RST = 8'h00;
    // power-up hold, in bit clock cycles
    localparam int PWRUP_CYCLES = 25;
    localparam int WORD_BITS = 8;
    localparam int FIFO_DEPTH = 16;
endpackage : cscd_pkg
`default_nettype wire

// file: verilog/cscd_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cscd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    logic full;
    logic empty;
    assign full = (wp_ff[AW-1:0] == rp_ff[AW-1:0]) && (wp_ff[AW] != rp_ff[AW]);
    assign empty = (wp_ff == rp_ff);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_ff[AW-1:0]];
    always_ff @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem[wp_ff[AW-1:0]] <= in_data;
        end
        if (srst) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (in_valid && !full) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule : cscd_fifo
`default_nettype wire

// file: verilog/cscd_top.sv
// codec serial control decoder: frame slot timing, control word load, pcm loopback
// assumes bit clock, strobe and serial inputs are synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module cscd_top (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic bit_clock_2m048,
    input wire logic frame_strobe_n,
    input wire logic [1:0] control_address_level,
    input wire logic control_serial_in,
    input wire logic control_held,
    input wire logic pcm_serial_in,
    output logic pcm_serial_out,
    output logic pcm_out_en,
    input wire logic [7:0] enc_data,
    input wire logic enc_valid,
    output logic enc_ready,
    output logic [7:0] dec_data,
    output logic dec_valid,
    output logic [5:0] spare_drive_outputs,
    output logic [2:0] tx_gain_db,
    output logic [2:0] rx_atten_db,
    output logic [1:0] test_select,
    output logic powerdown,
    output logic digital_loopback,
    output logic analog_loopback,
    output logic analog_out_grounded,
    output logic analog_in_disconnected
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic clk_d;
        logic [4:0] pwr_cnt;
        logic [3:0] bit_cnt;
        logic in_slot;
        logic slot_pcm;
        logic [1:0] slot_ca;
        logic [7:0] ctl_sh;
        logic [7:0] pcm_sh;
        logic [7:0] out_sh;
        logic out_en;
        logic [7:0] glc;
        logic [7:0] otc;
        logic [7:0] dec;
        logic dec_v;
    } cscd_state_type;

    cscd_state_type cur_ff;
    cscd_state_type nxt_cur;
    logic rise;
    logic fall;
    logic pwr_hold;
    logic pin_mode;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_take;

    // control_held: address negative and control input held steady (pin mode)
    assign pin_mode = control_held && (control_address_level == cscd_pkg::CA_NEG);
    assign rise = bit_clock_2m048 && !cur_ff.clk_d;
    assign fall = !bit_clock_2m048 && cur_ff.clk_d;
    assign pwr_hold = (cur_ff.pwr_cnt != 5'(cscd_pkg::PWRUP_CYCLES));

    // encoder words wait here until the next pcm slot; back-pressure reaches the encoder
    cscd_fifo #(.WIDTH(8), .DEPTH(cscd_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .in_data(enc_data),
        .in_valid(enc_valid),
        .in_ready(enc_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
        shift_in = {v[6:0], b}; // msb first
    endfunction : shift_in

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic start;
        logic pcm_ok;
        start = 1'b0;
        pcm_ok = 1'b0;
        nxt_cur = cur_ff;
        nxt_cur.clk_d = bit_clock_2m048;
        nxt_cur.dec_v = 1'b0;
        fifo_take = 1'b0;
        if (rise && pwr_hold) begin
            nxt_cur.pwr_cnt = cur_ff.pwr_cnt + 5'h01;
        end
        // slot opens on the first rising bit clock edge with the strobe low
        if (rise && !frame_strobe_n && !cur_ff.in_slot) begin
            start = 1'b1;
            nxt_cur.in_slot = 1'b1;
            nxt_cur.bit_cnt = 4'h0;
            nxt_cur.slot_ca = control_address_level;
            pcm_ok = (control_address_level != cscd_pkg::CA_POS);
            nxt_cur.slot_pcm = pcm_ok;
            // pcm out is dropped during powerdown; digital loopback echoes last received byte
            nxt_cur.out_en = pcm_ok && !powerdown;
            if (cur_ff.glc[7:6] == cscd_pkg::FN_DIG_LOOP) begin
                nxt_cur.out_sh = cur_ff.pcm_sh;
                fifo_take = fifo_valid && pcm_ok; // encoder output discarded
            end else begin
                nxt_cur.out_sh = fifo_valid ? fifo_data : 8'h00;
                fifo_take = fifo_valid && pcm_ok;
            end
        end else if (rise && cur_ff.in_slot) begin
            nxt_cur.out_sh = {cur_ff.out_sh[6:0], 1'b0};
            if (cur_ff.bit_cnt == 4'(cscd_pkg::WORD_BITS)) begin
                nxt_cur.in_slot = 1'b0;
                nxt_cur.out_en = 1'b0;
            end
        end
        if (fall && cur_ff.in_slot && cur_ff.bit_cnt < 4'(cscd_pkg::WORD_BITS)) begin
            nxt_cur.ctl_sh = shift_in(cur_ff.ctl_sh, control_serial_in);
            if (cur_ff.slot_pcm) begin
                nxt_cur.pcm_sh = shift_in(cur_ff.pcm_sh, pcm_serial_in);
            end
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
            if (cur_ff.bit_cnt == 4'(cscd_pkg::WORD_BITS - 1)) begin
                // whole word in: only now touch the registers
                if (cur_ff.slot_pcm) begin
                    nxt_cur.dec = (cur_ff.glc[7:6] == cscd_pkg::FN_DIG_LOOP) ? 8'h00
                        : shift_in(cur_ff.pcm_sh, pcm_serial_in);
                    nxt_cur.dec_v = 1'b1;
                end
                if (!pwr_hold && !control_held) begin
                    case (cur_ff.slot_ca)
                        cscd_pkg::CA_NEG: begin
                            nxt_cur.glc = shift_in(cur_ff.ctl_sh, control_serial_in);
                            nxt_cur.otc = cscd_pkg::OTC_RST;
                        end
                        cscd_pkg::CA_DGND: begin
                            nxt_cur.glc = shift_in(cur_ff.ctl_sh, control_serial_in);
                        end
                        cscd_pkg::CA_POS: begin
                            nxt_cur.otc = shift_in(cur_ff.ctl_sh, control_serial_in);
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        if (start && pwr_hold) begin
            nxt_cur.out_en = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur_ff <= '0;
            // track the pin through reset so that leaving reset makes no false bit clock edge
            cur_ff.clk_d <= bit_clock_2m048;
            cur_ff.glc <= cscd_pkg::GLC_RST;
            cur_ff.otc <= cscd_pkg::OTC_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] fn;
    logic held_high;
    assign held_high = pin_mode && control_serial_in;
    // pin mode overrides the stored gain and test fields, and the function field at the mode outputs but not in the pcm loopback path,
    // and the spares only when held low; the stored values resume once serial words flow
    assign fn = pwr_hold ? cscd_pkg::FN_PWRDN
        : held_high ? cscd_pkg::FN_PWRDN
        : pin_mode ? cscd_pkg::FN_NORMAL : cur_ff.glc[7:6];
    assign powerdown = (fn == cscd_pkg::FN_PWRDN);
    assign digital_loopback = (fn == cscd_pkg::FN_DIG_LOOP);
    assign analog_loopback = (fn == cscd_pkg::FN_ANA_LOOP);
    assign analog_out_grounded = analog_loopback || powerdown;
    assign analog_in_disconnected = analog_loopback;
    assign tx_gain_db = (pin_mode || pwr_hold) ? 3'h0 : cur_ff.glc[cscd_pkg::TXG_LSB +: 3];
    assign rx_atten_db = (pin_mode || pwr_hold) ? 3'h0 : cur_ff.glc[cscd_pkg::RXG_LSB +: 3];
    assign test_select = (pin_mode || pwr_hold) ? 2'h0 : cur_ff.otc[cscd_pkg::TST_LSB +: 2];
    assign spare_drive_outputs = pin_mode && !control_serial_in ? 6'h3f
        : cur_ff.otc[cscd_pkg::SPARE_W-1:0];
    assign pcm_serial_out = cur_ff.out_sh[7];
    assign pcm_out_en = cur_ff.out_en && !powerdown;
    assign dec_data = cur_ff.dec;
    assign dec_valid = cur_ff.dec_v;

    ////////////////////////////////////////////////////////////////////////
    sequence word_done_s;
        fall && cur_ff.in_slot && cur_ff.bit_cnt == 4'h7;
    endsequence
    powerup_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        pwr_hold |-> powerdown && test_select == 2'h0)
        else $error("power-up hold not in powerdown");
    neg_clears_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and cur_ff.slot_ca == cscd_pkg::CA_NEG && !pwr_hold && !control_held
        |=> cur_ff.otc == 8'h00)
        else $error("output/test not cleared on negative-address word");
    pos_keeps_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and cur_ff.slot_ca == cscd_pkg::CA_POS |=> $stable(cur_ff.glc))
        else $error("gain register changed on positive-address word");
    dgnd_keeps_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and cur_ff.slot_ca == cscd_pkg::CA_DGND |=> $stable(cur_ff.otc))
        else $error("output/test changed on ground-address word");
    partial_word_a: assert property (@(posedge core_clk) disable iff (srst)
        !(fall && cur_ff.in_slot && cur_ff.bit_cnt == 4'h7) |=> $stable(cur_ff.glc) && $stable(cur_ff.otc))
        else $error("register changed before full word");
    pos_inhibit_a: assert property (@(posedge core_clk) disable iff (srst)
        cur_ff.in_slot && cur_ff.slot_ca == cscd_pkg::CA_POS |-> !pcm_out_en)
        else $error("pcm driven in positive-address slot");
    pin_high_a: assert property (@(posedge core_clk) disable iff (srst)
        held_high |-> powerdown && !pcm_out_en && analog_out_grounded)
        else $error("held-high pin mode not powered down");
    spares_map_a: assert property (@(posedge core_clk) disable iff (srst)
        !pin_mode |-> spare_drive_outputs == cur_ff.otc[5:0])
        else $error("spare outputs differ from register");
    dig_loop_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and cur_ff.slot_pcm && cur_ff.glc[7:6] == 2'h1 |=> dec_valid && dec_data == 8'h00)
        else $error("decoder input not zero in digital loopback");

    ////////////////////////////////////////////////////////////////////////
    // the word count closes a slot, not the strobe, so a late strobe cannot stretch it
    sequence slot_open_s;
        rise && !frame_strobe_n && !cur_ff.in_slot;
    endsequence
    sequence slot_close_s;
        rise && cur_ff.in_slot && cur_ff.bit_cnt == 4'h8;
    endsequence
    sequence load_ok_s;
        !pwr_hold && !control_held;
    endsequence
    reset_vals_a: assert property (@(posedge core_clk)
        srst |=> cur_ff.glc == cscd_pkg::GLC_RST && cur_ff.otc == cscd_pkg::OTC_RST)
        else $error("control registers not at power-up values");
    slot_start_a: assert property (@(posedge core_clk) disable iff (srst)
        slot_open_s |=> cur_ff.in_slot && cur_ff.bit_cnt == 4'h0
        && cur_ff.slot_ca == $past(control_address_level))
        else $error("slot did not open on strobe");
    slot_end_a: assert property (@(posedge core_clk) disable iff (srst)
        slot_close_s |=> !cur_ff.in_slot && !pcm_out_en)
        else $error("slot not closed after eight bits");
    pcm_drive_a: assert property (@(posedge core_clk) disable iff (srst)
        slot_open_s and load_ok_s and cur_ff.glc[7:6] == cscd_pkg::FN_NORMAL
        && control_address_level != cscd_pkg::CA_POS |=> cur_ff.out_en)
        else $error("pcm output not driven in its slot");
    dig_echo_a: assert property (@(posedge core_clk) disable iff (srst)
        slot_open_s and cur_ff.glc[7:6] == cscd_pkg::FN_DIG_LOOP |=> cur_ff.out_sh == $past(cur_ff.pcm_sh))
        else $error("digital loopback did not echo the received byte");
    hold_ignore_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and pwr_hold |=> $stable(cur_ff.glc) && $stable(cur_ff.otc))
        else $error("control word taken during power-up hold");
    held_ignore_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and control_held |=> $stable(cur_ff.glc) && $stable(cur_ff.otc))
        else $error("control word taken while control input held");
    neg_lsb_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and load_ok_s and cur_ff.slot_ca == cscd_pkg::CA_NEG
        |=> cur_ff.glc[0] == $past(control_serial_in))
        else $error("last control bit not in gain register bit 0");
    pos_lsb_a: assert property (@(posedge core_clk) disable iff (srst)
        word_done_s and load_ok_s and cur_ff.slot_ca == cscd_pkg::CA_POS
        |=> cur_ff.otc[0] == $past(control_serial_in))
        else $error("last control bit not in output/test bit 0");
    pin_normal_a: assert property (@(posedge core_clk) disable iff (srst)
        pin_mode && !control_serial_in |-> spare_drive_outputs == 6'h3f && tx_gain_db == 3'h0
        && rx_atten_db == 3'h0 && test_select == 2'h0 && (pwr_hold || !powerdown))
        else $error("pin-level normal mode not applied");
    gain_map_a: assert property (@(posedge core_clk) disable iff (srst)
        !pin_mode && !pwr_hold |-> tx_gain_db == cur_ff.glc[2:0] && rx_atten_db == cur_ff.glc[5:3])
        else $error("gain outputs differ from gain register");
    fn_map_a: assert property (@(posedge core_clk) disable iff (srst)
        !pin_mode && !pwr_hold |-> powerdown == (cur_ff.glc[7:6] == 2'h3)
        && digital_loopback == (cur_ff.glc[7:6] == 2'h1) && analog_loopback == (cur_ff.glc[7:6] == 2'h2))
        else $error("function outputs differ from gain register");
    dec_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
        dec_valid |=> !dec_valid)
        else $error("decoder strobe longer than one cycle");
    ana_loop_a: assert property (@(posedge core_clk) disable iff (srst)
        analog_loopback |-> analog_out_grounded && analog_in_disconnected && !digital_loopback)
        else $error("analog loopback routing incomplete");
endmodule : cscd_top
`default_nettype wire

// file: testbench/cscd_ctl_model.sv
// controller model: free bit clock, frame strobe, control and pcm bit streams
// assumes core_clk only; bit clock half period is 4 core cycles to keep runs short
`timescale 1ns/1ps
`default_nettype none
module cscd_ctl_model (
    input wire logic core_clk,
    input wire logic control_held,
    input wire logic pin_lvl,
    input wire logic pcm_serial_out,
    input wire logic pcm_out_en,
    output logic bit_clock_2m048,
    output logic frame_strobe_n,
    output logic [1:0] control_address_level,
    output logic control_serial_in,
    output logic pcm_serial_in
);
    logic [1:0] cnt = 2'h0;
    logic stall = 1'b0;
    initial begin
        bit_clock_2m048 = 1'b1;
        frame_strobe_n = 1'b1;
        control_address_level = cscd_pkg::CA_NEG;
        control_serial_in = 1'b0;
        pcm_serial_in = 1'b0;
    end
    // bit clock runs free: the power-up hold counts its rising edges
    always @(posedge core_clk) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) bit_clock_2m048 <= !bit_clock_2m048;
        // pin-level modes need the address at the negative level
        if (control_held && frame_strobe_n) begin
            control_serial_in <= pin_lvl;
            control_address_level <= cscd_pkg::CA_NEG;
        end
    end
    task automatic edge_wait(input logic rise);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(cnt == 2'h3 && bit_clock_2m048 == !rise) && n < 16);
        if (n == 16) stall = 1'b1;
    endtask : edge_wait
    // data changes on the rise, the device samples it on the fall
    task automatic slot(input logic [1:0] ca, input logic [7:0] cw, input logic [7:0] pw,
                        output logic [7:0] got, output logic en);
        en = 1'b0;
        edge_wait(1'b0);
        frame_strobe_n <= 1'b0;
        control_address_level <= ca;
        for (int i = 7; i >= 0; i--) begin
            edge_wait(1'b1);
            control_serial_in <= cw[i];
            pcm_serial_in <= pw[i];
            edge_wait(1'b0);
            got[i] = pcm_serial_out;
            en = en | pcm_out_en;
        end
        // hold the last bit until the device has sampled it on the eighth fall
        @(posedge core_clk);
        // released lines show the inverse of the last bit, never a stale copy
        frame_strobe_n <= 1'b1;
        control_serial_in <= !cw[0];
        pcm_serial_in <= !pw[0];
    endtask : slot
endmodule : cscd_ctl_model
`default_nettype wire

// file: testbench/tb.sv
// testbench: control words and pcm slots through the controller model
// assumes the model's bit clock of 8 core cycles a bit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic control_held = 1'b0;
    logic pin_lvl = 1'b0;
    logic [7:0] enc_data = 8'h00;
    logic enc_valid = 1'b0;
    wire logic bit_clock_2m048, frame_strobe_n, control_serial_in, pcm_serial_in, pcm_serial_out;
    wire logic pcm_out_en, enc_ready, dec_valid, powerdown, digital_loopback, analog_loopback;
    wire logic analog_out_grounded, analog_in_disconnected;
    wire logic [1:0] control_address_level, test_select;
    wire logic [7:0] dec_data;
    wire logic [5:0] spare_drive_outputs;
    wire logic [2:0] tx_gain_db, rx_atten_db;
    wire logic [7:0] gains = {test_select, rx_atten_db, tx_gain_db};
    wire logic [7:0] flags = {3'h0, powerdown, digital_loopback, analog_loopback, analog_out_grounded,
                              analog_in_disconnected};
    logic [7:0] got, last_dec;
    logic en;
    logic [7:0] fx [4] = '{8'h00, 8'h08, 8'h07, 8'h12};
    int failures = 0;
    int checked = 0;
    always #2.5 core_clk = !core_clk;
    always @(posedge core_clk) if (dec_valid) last_dec <= dec_data;
    cscd_top i_cscd_top (.core_clk, .srst, .bit_clock_2m048, .frame_strobe_n, .control_address_level,
        .control_serial_in, .control_held, .pcm_serial_in, .pcm_serial_out, .pcm_out_en, .enc_data,
        .enc_valid, .enc_ready, .dec_data, .dec_valid, .spare_drive_outputs, .tx_gain_db, .rx_atten_db,
        .test_select, .powerdown, .digital_loopback, .analog_loopback, .analog_out_grounded,
        .analog_in_disconnected);
    cscd_ctl_model i_cscd_ctl_model (.core_clk, .control_held, .pin_lvl, .pcm_serial_out, .pcm_out_en,
        .bit_clock_2m048, .frame_strobe_n, .control_address_level, .control_serial_in, .pcm_serial_in);
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // registers settle a cycle after the eighth fall; three edges leave margin
    task automatic s(input logic [1:0] ca, input logic [7:0] cw, input logic [7:0] pw);
        i_cscd_ctl_model.slot(ca, cw, pw, got, en);
        repeat (3) @(posedge core_clk);
        #1;
    endtask : s
    initial begin
        for (int n = 0; n < 20000 && !i_cscd_ctl_model.stall; n++) begin
            @(posedge core_clk);
        end
        check("watchdog", 8'h01, 8'h00);
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        check("gains", gains, 8'h00);
        check("flags", flags, 8'h12);
        check("spare", {2'h0, spare_drive_outputs}, 8'h00);
        s(cscd_pkg::CA_NEG, 8'h1d, 8'h00);
        check("hold gains", gains, 8'h00);
        check("hold flags", flags, 8'h12);
        repeat (240) @(posedge core_clk);
        #1;
        check("post hold gains", gains, 8'h00);
        check("post hold flags", flags, 8'h12);
        $display("test reset done");
        s(cscd_pkg::CA_POS, 8'hab, 8'h00);
        check("spare", {2'h0, spare_drive_outputs}, 8'h2b);
        check("gains", gains, 8'h80);
        check("pcm en", {7'h0, en}, 8'h00);
        s(cscd_pkg::CA_DGND, 8'h1d, 8'h00);
        check("gains", gains, 8'h9d);
        check("spare", {2'h0, spare_drive_outputs}, 8'h2b);
        for (int f = 0; f < 4; f++) begin
            s(cscd_pkg::CA_DGND, {f[1:0], 6'h00}, 8'h00);
            check("function", flags, fx[f]);
        end
        s(cscd_pkg::CA_NEG, 8'h07, 8'h00);
        check("gains", gains, 8'h07);
        check("spare", {2'h0, spare_drive_outputs}, 8'h00);
        s(cscd_pkg::CA_BAD, 8'hff, 8'h00);
        check("bad address", gains, 8'h07);
        $display("test modes done");
        s(cscd_pkg::CA_DGND, 8'h40, 8'h00);
        s(cscd_pkg::CA_DGND, 8'h40, 8'h5a);
        check("decoder in", last_dec, 8'h00);
        s(cscd_pkg::CA_DGND, 8'h40, 8'h00);
        check("echo", got, 8'h5a);
        s(cscd_pkg::CA_DGND, 8'h00, 8'h00);
        $display("test loopback done");
        @(posedge core_clk);
        control_held <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("pin spare", {2'h0, spare_drive_outputs}, 8'h3f);
        check("pin gains", gains, 8'h00);
        check("pin flags", flags, 8'h00);
        @(posedge core_clk);
        pin_lvl <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("pin pd", flags, 8'h12);
        check("pin oe", {7'h0, pcm_out_en}, 8'h00);
        @(posedge core_clk);
        control_held <= 1'b0;
        $display("test pin mode done");
        // fifo is empty here, so sixteen pushes in a row must all be taken
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            enc_data <= 8'h10 + i[7:0];
            enc_valid <= 1'b1;
        end
        @(posedge core_clk);
        enc_valid <= 1'b0;
        #1;
        check("full", {7'h0, enc_ready}, 8'h00);
        s(cscd_pkg::CA_POS, 8'h00, 8'h00);
        check("pos pcm en", {7'h0, en}, 8'h00);
        check("pos keeps fifo", {7'h0, enc_ready}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            s(cscd_pkg::CA_DGND, 8'h00, 8'ha0 + i[7:0]);
            check("pcm out", got, 8'h10 + i[7:0]);
            check("pcm en", {7'h0, en}, 8'h01);
            check("decoder in", last_dec, 8'ha0 + i[7:0]);
        end
        check("drained", {7'h0, enc_ready}, 8'h01);
        $display("test fifo done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
